// File: core/slb_strap_latch.sv
// slb_strap_latch: samples the four strap pins at reset, holds them, and
// publishes them and their decoded boot settings over Avalon-MM
// assumes strap and power-up pins are asynchronous; fuses and the system
// reset event come from logic on i_clk_sys
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module slb_strap_latch
  import slb_pkg::*;
#(
  parameter int HOLD_CNT = HOLD_CYCLES
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // pins
  input wire logic i_chip_power_up,
  input wire logic i_boot_strap_a,
  input wire logic i_supply_strap,
  input wire logic i_boot_strap_b,
  input wire logic i_debug_source_strap,
  // other system reset sources, one-cycle pulse
  input wire logic i_sys_reset_evt,
  // fuse bits
  input wire logic i_jtag_strap_select_fuse,
  input wire logic i_usb_debug_disable_fuse,
  input wire logic i_pad_debug_disable_fuse,
  input wire logic i_flash_supply_force_fuse,
  input wire logic i_flash_supply_level_fuse,
  input wire logic i_log_disable_fuse,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // pin control
  output logic [STRAP_W-1:0] o_strap_pull_up,
  output logic [STRAP_W-1:0] o_strap_pull_down,
  output logic o_strap_release,
  // decoded settings
  output logic o_strap_valid,
  output logic o_boot_flash,
  output logic o_boot_bad,
  output logic o_dbg_pads,
  output logic o_dbg_usb,
  output logic o_supply_1v8,
  output logic o_log_en
);

  localparam int CNT_W = $clog2(HOLD_CNT + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HOLD_CNT - 1);

  // pin synchronisation
  logic [STRAP_W:0] pins_async;
  logic [STRAP_W:0] pins_sync;
  logic pu_sync;
  logic [STRAP_W-1:0] strap_sync;

  assign pins_async[BIT_BOOT_A] = i_boot_strap_a;
  assign pins_async[BIT_SUPPLY] = i_supply_strap;
  assign pins_async[BIT_BOOT_B] = i_boot_strap_b;
  assign pins_async[BIT_DEBUG] = i_debug_source_strap;
  assign pins_async[STRAP_W] = i_chip_power_up;

  slb_sync #(
    .W(STRAP_W + 1)
  ) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_async(pins_async),
    .o_sync(pins_sync)
  );

  assign pu_sync = pins_sync[STRAP_W];
  assign strap_sync = pins_sync[STRAP_W-1:0];

  // strap sequencer
  slb_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [STRAP_W-1:0] strap_q, strap_d;
  logic valid_q, valid_d;
  logic capture_q, capture_d;
  logic [STRAP_W-1:0] pull_up_q, pull_up_d;
  logic [STRAP_W-1:0] pull_dn_q, pull_dn_d;
  logic release_q, release_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    strap_d = strap_q;
    valid_d = valid_q;
    capture_d = 1'b0;
    case (state_q)
      ST_PULL: begin
        cnt_d = '0;
        if (pu_sync) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // sample at the end of the hold window, when levels are settled
        if (!pu_sync) begin
          state_d = ST_PULL;
        end else if (cnt_q == CNT_LAST) begin
          strap_d = strap_sync;
          valid_d = 1'b1;
          capture_d = 1'b1;
          state_d = ST_RUN;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      ST_RUN: begin
        state_d = ST_RUN;
      end
      default: state_d = ST_PULL;
    endcase
    // any system reset source starts a fresh sampling pass
    if (i_sys_reset_evt || (state_q != ST_PULL && !pu_sync &&
        state_q != ST_HOLD)) begin
      state_d = ST_PULL;
      valid_d = 1'b0;
      cnt_d = '0;
    end
    // pulls only while the straps are being sampled
    if (state_d == ST_RUN) begin
      pull_up_d = '0;
      pull_dn_d = '0;
      release_d = 1'b1;
    end else begin
      pull_up_d = PULL_UP_MASK;
      pull_dn_d = PULL_DN_MASK;
      release_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= ST_PULL;
      cnt_q <= '0;
      strap_q <= RST_STRAP;
      valid_q <= 1'b0;
      capture_q <= 1'b0;
      pull_up_q <= PULL_UP_MASK;
      pull_dn_q <= PULL_DN_MASK;
      release_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      strap_q <= strap_d;
      valid_q <= valid_d;
      capture_q <= capture_d;
      pull_up_q <= pull_up_d;
      pull_dn_q <= pull_dn_d;
      release_q <= release_d;
    end
  end

  // software control register
  logic log_off_q, log_off_d;

  // decoded settings
  logic boot_flash, boot_bad, dbg_pads, dbg_usb, supply_1v8, log_en;

  slb_decode u_decode (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_strap(strap_q),
    .i_capture(capture_q),
    .i_jtag_strap_select_fuse(i_jtag_strap_select_fuse),
    .i_usb_debug_disable_fuse(i_usb_debug_disable_fuse),
    .i_pad_debug_disable_fuse(i_pad_debug_disable_fuse),
    .i_flash_supply_force_fuse(i_flash_supply_force_fuse),
    .i_flash_supply_level_fuse(i_flash_supply_level_fuse),
    .i_log_disable_fuse(i_log_disable_fuse),
    .i_log_off(log_off_q),
    .o_boot_flash(boot_flash),
    .o_boot_bad(boot_bad),
    .o_dbg_pads(dbg_pads),
    .o_dbg_usb(dbg_usb),
    .o_supply_1v8(supply_1v8),
    .o_log_en(log_en)
  );

  // avalon slave: one wait cycle, answer on the second edge of a request
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic req;

  assign req = i_avs_read | i_avs_write;

  always_comb begin
    wait_d = 1'b1;
    rdata_d = rdata_q;
    log_off_d = log_off_q;
    if (req && wait_q) begin
      wait_d = 1'b0;
      rdata_d = RST_RDATA;
      if (i_avs_address == OFS_STRAP) begin
        rdata_d[STRAP_W-1:0] = strap_q;
        rdata_d[STS_VALID] = valid_q;
      end else if (i_avs_address == OFS_CTRL) begin
        rdata_d[CTRL_LOG_OFF] = log_off_q;
      end else if (i_avs_address == OFS_DECODE) begin
        rdata_d[DEC_BOOT_FLASH] = boot_flash;
        rdata_d[DEC_BOOT_BAD] = boot_bad;
        rdata_d[DEC_DBG_PADS] = dbg_pads;
        rdata_d[DEC_DBG_USB] = dbg_usb;
        rdata_d[DEC_SUPPLY_1V8] = supply_1v8;
        rdata_d[DEC_LOG_EN] = log_en;
      end
    end
    // write lands on the completing edge, when waitrequest is low
    if (i_avs_write && !wait_q && i_avs_address == OFS_CTRL &&
        i_avs_byteenable[0]) begin
      log_off_d = i_avs_writedata[CTRL_LOG_OFF];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      wait_q <= 1'b1;
      rdata_q <= RST_RDATA;
      log_off_q <= RST_LOG_OFF;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      log_off_q <= log_off_d;
    end
  end

  assign o_avs_readdata = rdata_q;
  assign o_avs_waitrequest = wait_q;
  assign o_strap_pull_up = pull_up_q;
  assign o_strap_pull_down = pull_dn_q;
  assign o_strap_release = release_q;
  assign o_strap_valid = valid_q;
  assign o_boot_flash = boot_flash;
  assign o_boot_bad = boot_bad;
  assign o_dbg_pads = dbg_pads;
  assign o_dbg_usb = dbg_usb;
  assign o_supply_1v8 = supply_1v8;
  assign o_log_en = log_en;

endmodule

// File: inc/slb_pkg.sv
// slb_pkg: shared constants of the strap latch and boot configuration block
// assumes a single 250 MHz system clock and an Avalon-MM register port
package slb_pkg;

  // strap vector layout
  localparam int STRAP_W = 4;
  localparam int BIT_BOOT_A = 0;
  localparam int BIT_SUPPLY = 1;
  localparam int BIT_BOOT_B = 2;
  localparam int BIT_DEBUG = 3;

  // weak pulls applied while reset holds the straps
  localparam logic [3:0] PULL_UP_MASK = 4'h1;
  localparam logic [3:0] PULL_DN_MASK = 4'h6;

  // timing
  localparam int CLK_MHZ = 250;
  localparam int T_HOLD_MS = 3;
  localparam int HOLD_CYCLES = T_HOLD_MS * CLK_MHZ * 1000;

  // register map, byte addresses
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_STRAP = 4'h0;
  localparam logic [3:0] OFS_CTRL = 4'h4;
  localparam logic [3:0] OFS_DECODE = 4'h8;

  // field positions
  localparam int STS_VALID = 8;
  localparam int CTRL_LOG_OFF = 0;
  localparam int DEC_BOOT_FLASH = 0;
  localparam int DEC_BOOT_BAD = 1;
  localparam int DEC_DBG_PADS = 2;
  localparam int DEC_DBG_USB = 3;
  localparam int DEC_SUPPLY_1V8 = 4;
  localparam int DEC_LOG_EN = 5;

  // reset values
  localparam logic [3:0] RST_STRAP = 4'h0;
  localparam logic RST_LOG_OFF = 1'b0;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_PULL = 3'b001,
    ST_HOLD = 3'b010,
    ST_RUN  = 3'b100
  } slb_state_t;

endpackage

// File: core/slb_sync.sv
// slb_sync: two-flop synchroniser for a group of pin levels
// assumes inputs are asynchronous to i_clk_sys
`timescale 1ns/1ps
module slb_sync #(
  parameter int W = 5
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // pins in, synchronised levels out
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
          meta_q[g] <= 1'b0;
          sync_q[g] <= 1'b0;
        end else begin
          meta_q[g] <= i_async[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  assign o_sync = sync_q;

endmodule

// File: core/slb_decode.sv
// slb_decode: turns latched straps and fuse bits into boot settings
// assumes i_capture pulses once when the strap latch takes its value
`timescale 1ns/1ps
module slb_decode
  import slb_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // latched straps and capture strobe
  input wire logic [STRAP_W-1:0] i_strap,
  input wire logic i_capture,
  // fuse bits
  input wire logic i_jtag_strap_select_fuse,
  input wire logic i_usb_debug_disable_fuse,
  input wire logic i_pad_debug_disable_fuse,
  input wire logic i_flash_supply_force_fuse,
  input wire logic i_flash_supply_level_fuse,
  input wire logic i_log_disable_fuse,
  // software log suppression
  input wire logic i_log_off,
  // decoded settings
  output logic o_boot_flash,
  output logic o_boot_bad,
  output logic o_dbg_pads,
  output logic o_dbg_usb,
  output logic o_supply_1v8,
  output logic o_log_en
);

  logic boot_flash_q, boot_flash_d;
  logic boot_bad_q, boot_bad_d;
  logic dbg_pads_q, dbg_pads_d;
  logic dbg_usb_q, dbg_usb_d;
  logic supply_1v8_q, supply_1v8_d;
  logic log_en_q, log_en_d;

  always_comb begin
    boot_flash_d = boot_flash_q;
    boot_bad_d = boot_bad_q;
    dbg_pads_d = dbg_pads_q;
    dbg_usb_d = dbg_usb_q;
    supply_1v8_d = supply_1v8_q;
    // boot, debug and supply settings only move at capture, so they stay fixed afterwards
    if (i_capture) begin
      boot_flash_d = i_strap[BIT_BOOT_A];
      boot_bad_d = i_strap[BIT_BOOT_B] & ~i_strap[BIT_BOOT_A];
      dbg_pads_d = 1'b0;
      dbg_usb_d = 1'b0;
      case ({i_usb_debug_disable_fuse, i_pad_debug_disable_fuse})
        2'b00: begin
          if (i_jtag_strap_select_fuse) begin
            dbg_pads_d = ~i_strap[BIT_DEBUG];
            dbg_usb_d = i_strap[BIT_DEBUG];
          end else begin
            dbg_usb_d = 1'b1;
          end
        end
        2'b01: dbg_usb_d = 1'b1;
        2'b10: dbg_pads_d = 1'b1;
        default: begin
          dbg_pads_d = 1'b0;
          dbg_usb_d = 1'b0;
        end
      endcase
      if (i_flash_supply_force_fuse) begin
        supply_1v8_d = ~i_flash_supply_level_fuse;
      end else begin
        supply_1v8_d = i_strap[BIT_SUPPLY];
      end
    end
    // console and usb log both on unless register or fuse says off
    log_en_d = ~(i_log_off | i_log_disable_fuse);
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      boot_flash_q <= 1'b0;
      boot_bad_q <= 1'b0;
      dbg_pads_q <= 1'b0;
      dbg_usb_q <= 1'b0;
      supply_1v8_q <= 1'b0;
      log_en_q <= 1'b0;
    end else begin
      boot_flash_q <= boot_flash_d;
      boot_bad_q <= boot_bad_d;
      dbg_pads_q <= dbg_pads_d;
      dbg_usb_q <= dbg_usb_d;
      supply_1v8_q <= supply_1v8_d;
      log_en_q <= log_en_d;
    end
  end

  assign o_boot_flash = boot_flash_q;
  assign o_boot_bad = boot_bad_q;
  assign o_dbg_pads = dbg_pads_q;
  assign o_dbg_usb = dbg_usb_q;
  assign o_supply_1v8 = supply_1v8_q;
  assign o_log_en = log_en_q;

endmodule

// File: testbench/slb_board_model.sv
// slb_board_model: board side of the four strap pins
// assumes the device's pull and release outputs; one clock
`timescale 1ns/1ps
module slb_board_model
  import slb_pkg::*;
(
  // clock
  input wire logic i_clk_sys,
  // board drive and device pin control
  input wire logic [STRAP_W-1:0] i_drive_en,
  input wire logic [STRAP_W-1:0] i_drive_val,
  input wire logic [STRAP_W-1:0] i_pull_up,
  input wire logic [STRAP_W-1:0] i_pull_down,
  input wire logic i_release,
  // pin levels seen by the device
  output logic [STRAP_W-1:0] o_pins
);
  logic [STRAP_W-1:0] last_q = '0;
  always_ff @(posedge i_clk_sys) begin
    last_q <= o_pins;
  end
  // a floating or reused pin must not look like the latched level
  always_comb begin
    for (int i = 0; i < STRAP_W; i++) begin
      if (i_release) o_pins[i] = ~last_q[i];
      else if (i_drive_en[i] || i == BIT_DEBUG) o_pins[i] = i_drive_val[i];
      else if (i_pull_up[i]) o_pins[i] = 1'b1;
      else if (i_pull_down[i]) o_pins[i] = 1'b0;
      else o_pins[i] = ~last_q[i];
    end
  end
endmodule

// File: testbench/slb_strap_latch_asserts.sv
// checker: port-level timing and decode checks of slb_strap_latch
// assumes one clock domain; attached by the bind at the foot
`timescale 1ns/1ps
module slb_strap_latch_asserts
  import slb_pkg::*;
#(
  parameter int HOLD_CNT = HOLD_CYCLES
) (
  // clock, reset, pins and fuses
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_chip_power_up,
  input wire logic i_boot_strap_a,
  input wire logic i_supply_strap,
  input wire logic i_boot_strap_b,
  input wire logic i_debug_source_strap,
  input wire logic i_sys_reset_evt,
  input wire logic i_jtag_strap_select_fuse,
  input wire logic i_usb_debug_disable_fuse,
  input wire logic i_pad_debug_disable_fuse,
  input wire logic i_flash_supply_force_fuse,
  input wire logic i_flash_supply_level_fuse,
  input wire logic i_log_disable_fuse,
  // bus
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  // pin control and decode
  input wire logic [STRAP_W-1:0] o_strap_pull_up,
  input wire logic [STRAP_W-1:0] o_strap_pull_down,
  input wire logic o_strap_release,
  input wire logic o_strap_valid,
  input wire logic o_boot_flash,
  input wire logic o_boot_bad,
  input wire logic o_dbg_pads,
  input wire logic o_dbg_usb,
  input wire logic o_supply_1v8,
  input wire logic o_log_en
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  logic [31:0] hi_q;
  logic exp_usb, exp_pads, exp_1v8, exp_bad;
  // log enable stays live after capture, so it is left out here
  logic [4:0] dec;
  assign exp_usb = !i_usb_debug_disable_fuse && (i_pad_debug_disable_fuse
    || !i_jtag_strap_select_fuse || i_debug_source_strap);
  assign exp_pads = !i_pad_debug_disable_fuse && (i_usb_debug_disable_fuse
    || (i_jtag_strap_select_fuse && !i_debug_source_strap));
  assign exp_1v8 = i_flash_supply_force_fuse ? !i_flash_supply_level_fuse
    : i_supply_strap;
  assign exp_bad = i_boot_strap_b && !i_boot_strap_a;
  assign dec = {o_supply_1v8, o_dbg_usb, o_dbg_pads, o_boot_bad,
    o_boot_flash};
  // cycles since power-up went high or the last reset event
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) hi_q <= '0;
    else if (!i_chip_power_up || i_sys_reset_evt) hi_q <= '0;
    else hi_q <= hi_q + 32'h0000_0001;
  end
  sequence s_cap;
    $rose(o_strap_valid);
  endsequence
  sequence s_req;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  // pins move once release is seen, so look two samples back
  property p_boot;
    s_cap |=> o_boot_flash == $past(i_boot_strap_a, 2)
      && o_boot_bad == $past(exp_bad, 2);
  endproperty
  property p_dbg;
    s_cap |=> o_dbg_usb == $past(exp_usb, 2)
      && o_dbg_pads == $past(exp_pads, 2);
  endproperty
  property p_supply;
    s_cap |=> o_supply_1v8 == $past(exp_1v8, 2);
  endproperty
  property p_hold;
    s_cap |-> hi_q >= HOLD_CNT && hi_q <= HOLD_CNT + 6;
  endproperty
  property p_pulls;
    o_strap_pull_up == (o_strap_release ? 4'h0 : PULL_UP_MASK)
      && o_strap_pull_down == (o_strap_release ? 4'h0 : PULL_DN_MASK);
  endproperty
  property p_rel;
    o_strap_valid == o_strap_release;
  endproperty
  property p_stable;
    o_strap_valid && $past(o_strap_valid, 2) |-> $stable(dec);
  endproperty
  property p_log;
    $past(i_log_disable_fuse) |-> !o_log_en;
  endproperty
  property p_ans;
    s_req |=> !o_avs_waitrequest;
  endproperty
  property p_one;
    $fell(o_avs_waitrequest) |=> o_avs_waitrequest;
  endproperty
  property p_unmap;
    s_req ##0 (i_avs_read && i_avs_address == 4'hC)
      |=> o_avs_readdata == 32'h0000_0000;
  endproperty
  a_boot: assert property (p_boot) else $error("boot mode");
  a_dbg: assert property (p_dbg) else $error("debug source");
  a_supply: assert property (p_supply) else $error("supply");
  a_hold: assert property (p_hold) else $error("capture time");
  a_pulls: assert property (p_pulls) else $error("pulls");
  a_rel: assert property (p_rel) else $error("release");
  a_stable: assert property (p_stable) else $error("decode moved");
  a_log: assert property (p_log) else $error("log on");
  a_ans: assert property (p_ans) else $error("no answer");
  a_one: assert property (p_one) else $error("long wait low");
  a_unmap: assert property (p_unmap) else $error("unmapped data");
endmodule
bind slb_strap_latch slb_strap_latch_asserts #(.HOLD_CNT(HOLD_CNT)) u_chk (
  .i_clk_sys, .i_resetn, .i_chip_power_up, .i_boot_strap_a, .i_supply_strap,
  .i_boot_strap_b, .i_debug_source_strap, .i_sys_reset_evt,
  .i_jtag_strap_select_fuse, .i_usb_debug_disable_fuse,
  .i_pad_debug_disable_fuse, .i_flash_supply_force_fuse,
  .i_flash_supply_level_fuse, .i_log_disable_fuse, .i_avs_address,
  .i_avs_read, .i_avs_write, .o_avs_readdata, .o_avs_waitrequest,
  .o_strap_pull_up, .o_strap_pull_down, .o_strap_release, .o_strap_valid,
  .o_boot_flash, .o_boot_bad, .o_dbg_pads, .o_dbg_usb, .o_supply_1v8,
  .o_log_en);

// File: testbench/slb_strap_latch_tb_top.sv
// slb_strap_latch_tb_top: random strap and fuse trials, then register checks
// assumes slb_pkg, the board model and the checker compiled before it
`timescale 1ns/1ps
module slb_strap_latch_tb_top
  import slb_pkg::*;
();
  localparam int HOLD = 16;
  localparam int PU_LOW = 12500;
  localparam int LIMIT = 80000;
  logic i_clk_sys, i_resetn = 1'b0, i_chip_power_up = 1'b0;
  logic i_sys_reset_evt = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic o_avs_waitrequest, o_strap_release, o_strap_valid;
  logic [3:0] i_avs_address = '0, i_avs_byteenable = '0, en = '0, dv = '0;
  logic [3:0] pins, o_strap_pull_up, o_strap_pull_down;
  logic [31:0] i_avs_writedata = '0, o_avs_readdata, q;
  logic [5:0] fz = '0, dec;
  int fail_count = 0, n_tests = 0, seed = 49, cyc = 0;
  slb_strap_latch #(.HOLD_CNT(HOLD)) i_dut (
    .i_clk_sys, .i_resetn, .i_chip_power_up, .i_sys_reset_evt,
    .i_boot_strap_a(pins[BIT_BOOT_A]), .i_supply_strap(pins[BIT_SUPPLY]),
    .i_boot_strap_b(pins[BIT_BOOT_B]), .i_debug_source_strap(pins[BIT_DEBUG]),
    .i_jtag_strap_select_fuse(fz[0]), .i_usb_debug_disable_fuse(fz[1]),
    .i_pad_debug_disable_fuse(fz[2]), .i_flash_supply_force_fuse(fz[3]),
    .i_flash_supply_level_fuse(fz[4]), .i_log_disable_fuse(fz[5]),
    .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
    .o_strap_pull_up, .o_strap_pull_down, .o_strap_release, .o_strap_valid,
    .o_boot_flash(dec[0]), .o_boot_bad(dec[1]), .o_dbg_pads(dec[2]),
    .o_dbg_usb(dec[3]), .o_supply_1v8(dec[4]), .o_log_en(dec[5]));
  slb_board_model i_board (.i_clk_sys, .i_drive_en(en), .i_drive_val(dv),
    .i_pull_up(o_strap_pull_up), .i_pull_down(o_strap_pull_down),
    .i_release(o_strap_release), .o_pins(pins));
  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  function automatic logic [3:0] strap_of(logic [3:0] e, logic [3:0] v);
    logic [3:0] d;
    d = e | 4'h8;
    return (d & v) | (~d & PULL_UP_MASK);
  endfunction
  function automatic logic [5:0] exp_dec(logic [3:0] s, logic [5:0] f,
                                         logic off);
    logic u, p;
    u = !f[1] && (f[2] || !f[0] || s[BIT_DEBUG]);
    p = !f[2] && (f[1] || (f[0] && !s[BIT_DEBUG]));
    return {!(off || f[5]), f[3] ? !f[4] : s[BIT_SUPPLY], u, p,
            s[BIT_BOOT_B] && !s[BIT_BOOT_A], s[BIT_BOOT_A]};
  endfunction
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] rq);
    @(posedge i_clk_sys);
    i_avs_read <= !wr;
    i_avs_write <= wr;
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_byteenable <= be;
    // hold until the edge that sees waitrequest low; data taken there
    do @(posedge i_clk_sys); while (o_avs_waitrequest !== 1'b0);
    rq = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    logic [3:0] s, e, v;
    logic [5:0] f;
    repeat (10) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    // low fuse bits walk all eight debug fuse combinations
    for (int t = 0; t < 10; t++) begin
      e = 4'($random(seed));
      v = 4'($random(seed));
      f = {3'($random(seed)), 3'(t)};
      s = strap_of(e, v);
      if (s[BIT_BOOT_B] && !s[BIT_BOOT_A]) begin
        e[BIT_BOOT_A] = 1'b1;
        v[BIT_BOOT_A] = 1'b1;
        s[BIT_BOOT_A] = 1'b1;
      end
      @(posedge i_clk_sys);
      en <= e;
      dv <= v;
      fz <= f;
      if (t % 2 == 0) begin
        i_chip_power_up <= 1'b0;
        repeat (PU_LOW) @(posedge i_clk_sys);
        i_chip_power_up <= 1'b1;
      end else begin
        i_sys_reset_evt <= 1'b1;
        @(posedge i_clk_sys);
        i_sys_reset_evt <= 1'b0;
      end
      repeat (3) @(posedge i_clk_sys);
      while (o_strap_valid !== 1'b1) @(negedge i_clk_sys);
      bus(1'b0, OFS_STRAP, '0, 4'hF, q);
      chk("strap", q, {23'h0, 1'b1, 4'h0, s});
      bus(1'b0, OFS_DECODE, '0, 4'hF, q);
      chk("decode", q, {26'h0, exp_dec(s, f, 1'b0)});
      chk("dec_pins", {26'h0, dec}, {26'h0, exp_dec(s, f, 1'b0)});
      repeat (8) @(posedge i_clk_sys);
      bus(1'b0, OFS_STRAP, '0, 4'hF, q);
      chk("strap_kept", q, {23'h0, 1'b1, 4'h0, s});
      chk("pulls", {24'h0, o_strap_pull_up, o_strap_pull_down}, '0);
    end
    bus(1'b1, OFS_CTRL, 32'h0000_0001, 4'h0, q);
    bus(1'b0, OFS_CTRL, '0, 4'hF, q);
    chk("ctrl_no_lane", q, '0);
    bus(1'b1, 4'hC, 32'hFFFF_FFFF, 4'hF, q);
    bus(1'b0, 4'hC, '0, 4'hF, q);
    chk("unmapped", q, '0);
    bus(1'b1, OFS_STRAP, 32'hFFFF_FFFF, 4'hF, q);
    bus(1'b0, OFS_STRAP, '0, 4'hF, q);
    chk("strap_ro", q, {23'h0, 1'b1, 4'h0, s});
    bus(1'b1, OFS_CTRL, 32'h0000_0001, 4'h1, q);
    bus(1'b0, OFS_CTRL, '0, 4'hF, q);
    chk("ctrl", q, 32'h0000_0001);
    bus(1'b0, OFS_DECODE, '0, 4'hF, q);
    chk("log_off", q, {26'h0, exp_dec(s, f, 1'b1)});
    stop_test();
  end
endmodule
